// [design/lsdm_dev_cmp.sv]
`timescale 1ns/1ps
`default_nettype none
module lsdm_dev_cmp
   import lsdm_pkg::*;
(
   lsdm_cmp_if.cmp chk // Operands in, outcome out
);
   logic signed [24:0] diff;

   //------------------------------------------------------------
   // Absolute difference and threshold test
   //------------------------------------------------------------
   // Sign extension keeps the subtraction from wrapping
   assign diff = {chk.model[23], chk.model} - {chk.fback[23], chk.fback};
   assign chk.dev = diff[24] ? lsdm_mag_t'(-diff) : lsdm_mag_t'(diff); // RULE_12
   // Disabled check never hits
   always_comb begin
      if (!chk.enable) begin // RULE_05
         chk.hit = 1'b0;
      end else if (chk.strict) begin
         chk.hit = chk.dev > {9'h000, chk.limit}; // RULE_08
      end else begin
         chk.hit = chk.dev >= {9'h000, chk.limit}; // RULE_06
      end
   end
endmodule
`default_nettype wire

// [design/lsdm_monitor.sv]
// Notes on behaviour
// RULE_01: Select value bit 1 enables position check
// RULE_02: Select value bit 2 enables speed check
// RULE_03: Select value bit 4 enables thrust check
// RULE_04: Selection resets to 3: position and speed
// RULE_05: Disabled check never raises its alarm
// RULE_06: Position difference at or above limit alarms
// RULE_07: Position limit 1 to 1000 mm, default 50
// RULE_08: Speed difference strictly above limit alarms
// RULE_09: Speed limit 1 to 5000 mm/s, default 1000
// RULE_10: Thrust above limit alarms; 1-1000%, default 100
// RULE_11: Any combination 1..7, checks act independently
// RULE_12: Absolute difference each cycle; alarms latch until cleared
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lsdm_consts.svh"
module lsdm_monitor
   import lsdm_pkg::*;
(
   input wire logic clk_in, // 25 MHz system clock
   input wire logic rstn_in, // Async reset, active low
   // APB slave
   input wire logic psel_in, // Slave select
   input wire logic penable_in, // Access phase
   input wire logic pwrite_in, // Write when high
   input wire logic [7:0] paddr_in, // Byte address
   input wire logic [31:0] pwdata_in, // Write data
   output logic [31:0] prdata_out, // Read data
   output logic pready_out, // Transfer done
   output logic pslverr_out, // Unmapped address
   // Servo control model and encoder feedback
   input wire logic sample_valid_in, // One control cycle of data
   input wire lsdm_val_t model_pos_in, // Model feedback position
   input wire lsdm_val_t fback_pos_in, // Encoder position
   input wire lsdm_val_t model_spd_in, // Model feedback speed
   input wire lsdm_val_t fback_spd_in, // Encoder speed
   input wire lsdm_val_t cmd_thr_in, // Command thrust
   input wire lsdm_val_t fback_thr_in, // Feedback thrust
   // Protective outputs
   output logic position_deviation_alarm_out, // Latched alarm
   output logic speed_deviation_alarm_out, // Latched alarm
   output logic thrust_deviation_alarm_out, // Latched alarm
   output logic motor_stop_out, // Stop command to the drive
   output logic irq_out // Unmasked alarm pending
);

   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   lsdm_apb_st_t apb_st_reg;
   lsdm_apb_st_t apb_st_next;
   logic [2:0] deviation_check_select_reg;
   lsdm_lim_t position_deviation_limit_reg;
   lsdm_lim_t speed_deviation_limit_reg;
   lsdm_lim_t thrust_deviation_limit_reg;
   logic [2:0] mask_reg;
   logic [2:0] live_hit_reg;
   logic motor_stop_reg;
   lsdm_mag_t peak_reg [3];
   logic [31:0] prdata_reg;
   logic [2:0] status;
   logic [2:0] alarm_set;
   logic [2:0] alarm_clr;
   logic [2:0] hit;
   logic [2:0] chk_en;
   lsdm_mag_t dev [3];
   logic wr_acc;
   logic rd_setup;
   logic [3:0] idx_w;
   logic [3:0] idx_r;

   lsdm_cmp_if chk_if [3] ();

   //------------------------------------------------------------
   // Functions
   //------------------------------------------------------------
   // Address to register index; 4'hf means unmapped
   function automatic logic [3:0] reg_index(input logic [7:0] addr);
      logic [3:0] idx;
      idx = 4'hf;
      if (addr[1:0] == 2'h0 && addr <= `LSDM_OFF_PEAK_THR) begin
         idx = addr[5:2];
      end
      return idx;
   endfunction

   // Hold a written setting inside its accepted range
   function automatic lsdm_lim_t clamp_lim(input logic [31:0] wd,
         input lsdm_lim_t lo, input lsdm_lim_t hi);
      lsdm_lim_t res;
      res = lo;
      if (wd > {16'h0000, hi}) begin
         res = hi;
      end else if (wd >= {16'h0000, lo}) begin
         res = wd[15:0];
      end
      return res;
   endfunction

   //------------------------------------------------------------
   // APB phase tracking
   //------------------------------------------------------------
   // Zero wait states: every access phase completes at once
   always_comb begin
      case (apb_st_reg)
         LSDM_ST_IDLE: begin
            apb_st_next = psel_in ? LSDM_ST_SETUP : LSDM_ST_IDLE;
         end
         LSDM_ST_SETUP: begin
            apb_st_next = (psel_in && penable_in) ? LSDM_ST_ACCESS
               : (psel_in ? LSDM_ST_SETUP : LSDM_ST_IDLE);
         end
         LSDM_ST_ACCESS: begin
            apb_st_next = psel_in && !penable_in ? LSDM_ST_SETUP
               : LSDM_ST_IDLE;
         end
         default: begin
            apb_st_next = LSDM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         apb_st_reg <= LSDM_ST_IDLE;
      end else begin
         apb_st_reg <= apb_st_next;
      end
   end

   // Strobes: writes land at the access edge, reads are
   // captured at the setup edge so prdata comes from a flop
   assign wr_acc = psel_in && penable_in && pwrite_in;
   assign rd_setup = psel_in && !penable_in && !pwrite_in;
   assign idx_w = reg_index(paddr_in);
   assign idx_r = reg_index(paddr_in);
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && (idx_w == 4'hf);
   assign prdata_out = prdata_reg;

   //------------------------------------------------------------
   // Settings registers
   //------------------------------------------------------------
   // Selection keeps the three enable bits; upper bits read zero
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         deviation_check_select_reg <= `LSDM_RST_SELECT; // RULE_04
      end else if (wr_acc && idx_w == `LSDM_OFF_SELECT >> 2) begin
         deviation_check_select_reg <= pwdata_in[2:0]; // RULE_11
      end
   end

   // Out-of-range limits are clamped, never rejected, so the
   // monitor always runs with a legal threshold
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         position_deviation_limit_reg <= `LSDM_RST_POS_LIM; // RULE_07
      end else if (wr_acc && idx_w == `LSDM_OFF_POS_LIM >> 2) begin
         position_deviation_limit_reg <= clamp_lim(pwdata_in,
            `LSDM_POS_LIM_MIN, `LSDM_POS_LIM_MAX); // RULE_07
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         speed_deviation_limit_reg <= `LSDM_RST_SPD_LIM; // RULE_09
      end else if (wr_acc && idx_w == `LSDM_OFF_SPD_LIM >> 2) begin
         speed_deviation_limit_reg <= clamp_lim(pwdata_in,
            `LSDM_SPD_LIM_MIN, `LSDM_SPD_LIM_MAX); // RULE_09
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         thrust_deviation_limit_reg <= `LSDM_RST_THR_LIM; // RULE_10
      end else if (wr_acc && idx_w == `LSDM_OFF_THR_LIM >> 2) begin
         thrust_deviation_limit_reg <= clamp_lim(pwdata_in,
            `LSDM_THR_LIM_MIN, `LSDM_THR_LIM_MAX); // RULE_10
      end
   end

   // Interrupt mask, same layout as the status bits
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mask_reg <= 3'h0;
      end else if (wr_acc && idx_w == `LSDM_OFF_MASK >> 2) begin
         mask_reg <= pwdata_in[2:0];
      end
   end

   //------------------------------------------------------------
   // Deviation checks
   //------------------------------------------------------------
   // Each selection bit drives its own check alone
   assign chk_en[`LSDM_BIT_POS] =
      deviation_check_select_reg[`LSDM_BIT_POS]; // RULE_01
   assign chk_en[`LSDM_BIT_SPD] =
      deviation_check_select_reg[`LSDM_BIT_SPD]; // RULE_02
   assign chk_en[`LSDM_BIT_THR] =
      deviation_check_select_reg[`LSDM_BIT_THR]; // RULE_03

   // Position uses at-or-above, speed and thrust strictly above
   assign chk_if[LSDM_CHK_POS].model = model_pos_in;
   assign chk_if[LSDM_CHK_POS].fback = fback_pos_in;
   assign chk_if[LSDM_CHK_POS].limit = position_deviation_limit_reg;
   assign chk_if[LSDM_CHK_POS].strict = 1'b0; // RULE_06
   assign chk_if[LSDM_CHK_SPD].model = model_spd_in;
   assign chk_if[LSDM_CHK_SPD].fback = fback_spd_in;
   assign chk_if[LSDM_CHK_SPD].limit = speed_deviation_limit_reg;
   assign chk_if[LSDM_CHK_SPD].strict = 1'b1; // RULE_08
   assign chk_if[LSDM_CHK_THR].model = cmd_thr_in;
   assign chk_if[LSDM_CHK_THR].fback = fback_thr_in;
   assign chk_if[LSDM_CHK_THR].limit = thrust_deviation_limit_reg;
   assign chk_if[LSDM_CHK_THR].strict = 1'b1; // RULE_10

   // Three identical comparators; several may fire together
   for (genvar i = 0; i < 3; i++) begin : g_chk
      assign chk_if[i].enable = chk_en[i]; // RULE_11
      assign hit[i] = chk_if[i].hit;
      assign dev[i] = chk_if[i].dev;
      lsdm_dev_cmp u_cmp (
         .chk(chk_if[i])
      );
   end

   //------------------------------------------------------------
   // Alarm latching and stop command
   //------------------------------------------------------------
   // Evaluated only on control cycles carrying fresh data
   assign alarm_set = sample_valid_in ? hit : 3'h0; // RULE_12
   assign alarm_clr = (wr_acc && idx_w == `LSDM_OFF_STATUS >> 2)
      ? pwdata_in[2:0] : 3'h0;

   lsdm_sticky u_sticky (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .set_in(alarm_set),
      .clr_in(alarm_clr),
      .flag_out(status)
   );

   // Stop follows the latched alarms so it holds until cleared
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         motor_stop_reg <= 1'b0;
      end else begin
         motor_stop_reg <= |((status & ~alarm_clr) | alarm_set); // RULE_06
      end
   end

   // Most recent per-check outcome, for diagnosis
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         live_hit_reg <= 3'h0;
      end else if (sample_valid_in) begin
         live_hit_reg <= hit;
      end
   end

   // Peak deviation seen by each enabled check; any write to a
   // peak register restarts it, unless a fresh sample in that cycle exceeds the stored peak
   for (genvar i = 0; i < 3; i++) begin : g_peak
      always_ff @(posedge clk_in or negedge rstn_in) begin
         if (!rstn_in) begin
            peak_reg[i] <= 25'h0000000;
         end else if (sample_valid_in && chk_en[i] &&
               dev[i] > peak_reg[i]) begin
            peak_reg[i] <= dev[i];
         end else if (wr_acc &&
               idx_w == (`LSDM_OFF_PEAK_POS >> 2) + 4'(i)) begin
            peak_reg[i] <= 25'h0000000;
         end
      end
   end

   assign position_deviation_alarm_out = status[`LSDM_BIT_POS];
   assign speed_deviation_alarm_out = status[`LSDM_BIT_SPD];
   assign thrust_deviation_alarm_out = status[`LSDM_BIT_THR];
   assign motor_stop_out = motor_stop_reg;
   // Level interrupt while any unmasked alarm is latched
   assign irq_out = |(status & mask_reg);

   //------------------------------------------------------------
   // Read data
   //------------------------------------------------------------
   // Captured in setup so the access phase sees a stable flop
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_reg <= 32'h00000000;
      end else if (rd_setup) begin
         case (idx_r)
            4'h0: prdata_reg <= {29'h0, deviation_check_select_reg};
            4'h1: prdata_reg <= {16'h0, position_deviation_limit_reg};
            4'h2: prdata_reg <= {16'h0, speed_deviation_limit_reg};
            4'h3: prdata_reg <= {16'h0, thrust_deviation_limit_reg};
            4'h4: prdata_reg <= {29'h0, status};
            4'h5: prdata_reg <= {29'h0, mask_reg};
            4'h6: prdata_reg <= {28'h0, motor_stop_reg, live_hit_reg};
            4'h7: prdata_reg <= {7'h0, peak_reg[0]};
            4'h8: prdata_reg <= {7'h0, peak_reg[1]};
            4'h9: prdata_reg <= {7'h0, peak_reg[2]};
            default: prdata_reg <= 32'h00000000;
         endcase
      end
   end

endmodule
`default_nettype wire

// [design/lsdm_sticky.sv]
`timescale 1ns/1ps
`default_nettype none
module lsdm_sticky (
   input wire logic clk_in, // System clock
   input wire logic rstn_in, // Async reset, active low
   input wire logic [2:0] set_in, // Events this cycle
   input wire logic [2:0] clr_in, // Write-one-to-clear strobes
   output logic [2:0] flag_out // Latched flags
);
   logic [2:0] flag_reg;
   logic [2:0] flag_next;

   //------------------------------------------------------------
   // Sticky flags
   //------------------------------------------------------------
   // Set beats clear so an event in the clearing cycle survives
   assign flag_next = (flag_reg & ~clr_in) | set_in; // RULE_12
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         flag_reg <= 3'h0;
      end else begin
         flag_reg <= flag_next;
      end
   end
   assign flag_out = flag_reg;
endmodule
`default_nettype wire

// [inc/lsdm_cmp_if.sv]
`timescale 1ns/1ps
`default_nettype none
// One deviation check: operands, threshold and outcome
interface lsdm_cmp_if;
   import lsdm_pkg::*;
   lsdm_val_t model;
   lsdm_val_t fback;
   lsdm_lim_t limit;
   logic enable;
   logic strict;
   logic hit;
   lsdm_mag_t dev;
   modport ctl (output model, output fback, output limit,
      output enable, output strict, input hit, input dev);
   modport cmp (input model, input fback, input limit,
      input enable, input strict, output hit, output dev);
endinterface
`default_nettype wire

// [inc/lsdm_consts.svh]
`ifndef LSDM_CONSTS_SVH
`define LSDM_CONSTS_SVH

// Register byte offsets
`define LSDM_OFF_SELECT 8'h00
`define LSDM_OFF_POS_LIM 8'h04
`define LSDM_OFF_SPD_LIM 8'h08
`define LSDM_OFF_THR_LIM 8'h0c
`define LSDM_OFF_STATUS 8'h10
`define LSDM_OFF_MASK 8'h14
`define LSDM_OFF_LIVE 8'h18
`define LSDM_OFF_PEAK_POS 8'h1c
`define LSDM_OFF_PEAK_SPD 8'h20
`define LSDM_OFF_PEAK_THR 8'h24

// Field positions of the selection and alarm layout
`define LSDM_BIT_POS 0
`define LSDM_BIT_SPD 1
`define LSDM_BIT_THR 2

// Reset values
`define LSDM_RST_SELECT 3'h3
`define LSDM_RST_POS_LIM 16'h0032
`define LSDM_RST_SPD_LIM 16'h03e8
`define LSDM_RST_THR_LIM 16'h0064

// Accepted setting ranges
`define LSDM_POS_LIM_MIN 16'h0001
`define LSDM_POS_LIM_MAX 16'h03e8
`define LSDM_SPD_LIM_MIN 16'h0001
`define LSDM_SPD_LIM_MAX 16'h1388
`define LSDM_THR_LIM_MIN 16'h0001
`define LSDM_THR_LIM_MAX 16'h03e8

`endif

// [inc/lsdm_pkg.sv]
package lsdm_pkg;
   // Signed model or feedback quantity, in mm, mm/s or %
   typedef logic signed [23:0] lsdm_val_t;
   // Threshold setting
   typedef logic [15:0] lsdm_lim_t;
   // Magnitude of a difference, one bit wider than a value
   typedef logic [24:0] lsdm_mag_t;
   // Index of a deviation check
   typedef enum logic [1:0] {
      LSDM_CHK_POS = 2'h0,
      LSDM_CHK_SPD = 2'h1,
      LSDM_CHK_THR = 2'h2
   } lsdm_chk_t;
   // APB phase tracking
   typedef enum logic [2:0] {
      LSDM_ST_IDLE = 3'b001,
      LSDM_ST_SETUP = 3'b010,
      LSDM_ST_ACCESS = 3'b100
   } lsdm_apb_st_t;
endpackage

// [verif/lsdm_fb_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Servo model and encoder feedback source
// ----
module lsdm_fb_model
   import lsdm_pkg::*;
(
   input wire logic clk_in, // Clock
   input wire logic fire_in, // Send one sample
   input wire lsdm_val_t dp_in, // Position deviation wanted
   input wire lsdm_val_t ds_in, // Speed deviation wanted
   input wire lsdm_val_t dt_in, // Thrust deviation wanted
   output logic valid_out, // Sample strobe
   output lsdm_val_t mp_out, // Model position
   output lsdm_val_t fp_out, // Encoder position
   output lsdm_val_t ms_out, // Model speed
   output lsdm_val_t fs_out, // Encoder speed
   output lsdm_val_t ct_out, // Command thrust
   output lsdm_val_t ft_out // Feedback thrust
);
   lsdm_val_t base = 24'sh000000;
   // Moving operating point so values never sit still
   always @(posedge clk_in) begin
      base <= base + 24'sh000007;
   end
   // Off-sample values are far apart: a monitor that ignores the
   // strobe would alarm on them
   assign valid_out = fire_in;
   assign fp_out = base;
   assign fs_out = base;
   assign ft_out = base;
   assign mp_out = fire_in ? base + dp_in : base ^ 24'sh5a5a5a;
   assign ms_out = fire_in ? base + ds_in : base ^ 24'sh3c3c3c;
   assign ct_out = fire_in ? base + dt_in : base ^ 24'sh0f0f0f;
endmodule
`default_nettype wire

// [verif/lsdm_monitor_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checks for the deviation monitor
// ----
module lsdm_monitor_chk
   import lsdm_pkg::*;
(
   input wire logic clk_in, // Clock
   input wire logic rstn_in, // Reset, active low
   input wire logic psel_in, // Select
   input wire logic penable_in, // Access phase
   input wire logic pwrite_in, // Write
   input wire logic [7:0] paddr_in, // Address
   input wire logic [31:0] pwdata_in, // Write data
   input wire logic pready_out, // Ready
   input wire logic pslverr_out, // Error
   input wire logic sample_valid_in, // Sample strobe
   input wire lsdm_val_t model_pos_in, // Model position
   input wire lsdm_val_t fback_pos_in, // Encoder position
   input wire logic position_deviation_alarm_out, // Alarm
   input wire logic speed_deviation_alarm_out, // Alarm
   input wire logic thrust_deviation_alarm_out, // Alarm
   input wire logic motor_stop_out, // Stop
   input wire logic irq_out // Interrupt
);
   logic [2:0] al;
   logic clr;
   // Alarm vector and status write strobe
   assign al = {thrust_deviation_alarm_out, speed_deviation_alarm_out,
      position_deviation_alarm_out};
   assign clr = psel_in && penable_in && pwrite_in && paddr_in == 8'h10;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   // Stop is raised at the same edge as a fresh alarm
   sequence s_rise;
      $rose(al != 3'h0);
   endsequence
   sequence s_stop;
      motor_stop_out;
   endsequence
   property p_stop;
      s_rise |-> s_stop;
   endproperty
   a_stop: assert property (p_stop) else $error("stop late");
   // Stop tracks the latched alarms and drops with the last one
   property p_stop_hold;
      motor_stop_out == (al != 3'h0);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop");
   property p_latch;
      !clr |=> (al & $past(al)) == $past(al);
   endproperty
   a_latch: assert property (p_latch) else $error("alarm lost");
   property p_cause;
      (al & ~$past(al)) != 3'h0 |-> $past(sample_valid_in);
   endproperty
   a_cause: assert property (p_cause) else $error("no sample");
   // Limits are at least 1, so equal positions never alarm
   property p_pos_zero;
      sample_valid_in && model_pos_in == fback_pos_in &&
         !position_deviation_alarm_out |=> !position_deviation_alarm_out;
   endproperty
   a_pos_zero: assert property (p_pos_zero) else $error("pos");
   property p_clear;
      clr && pwdata_in[0] && !sample_valid_in |=>
         !position_deviation_alarm_out;
   endproperty
   a_clear: assert property (p_clear) else $error("clear");
   property p_irq;
      irq_out |-> al != 3'h0;
   endproperty
   a_irq: assert property (p_irq) else $error("irq without alarm");
   property p_err;
      psel_in && penable_in |->
         pslverr_out == (paddr_in > 8'h24 || paddr_in[1:0] != 2'h0);
   endproperty
   a_err: assert property (p_err) else $error("slverr");
   property p_ready;
      psel_in |-> pready_out;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low");
endmodule
bind lsdm_monitor lsdm_monitor_chk u_chk (.*);
`default_nettype wire

// [verif/lsdm_monitor_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lsdm_consts.svh"
module lsdm_monitor_tb_top;
   import lsdm_pkg::*;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, fire = 1'b0;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0, prd, q;
   logic rdy, err, err_q, vld, stp, irq, pal, sal, tal;
   lsdm_val_t dp = 24'sh0, ds = 24'sh0, dt = 24'sh0;
   lsdm_val_t mp, fp, ms, fs, ct, ft;
   int n_mismatch = 0, tests_run = 0, cyc = 0;
   wire logic [31:0] al = {29'h0, tal, sal, pal};
   // ----
   // Clock and parts
   // ----
   always #20 clk_in = ~clk_in;
   lsdm_fb_model u_src (.clk_in(clk_in), .fire_in(fire), .dp_in(dp),
      .ds_in(ds), .dt_in(dt), .valid_out(vld), .mp_out(mp),
      .fp_out(fp), .ms_out(ms), .fs_out(fs), .ct_out(ct), .ft_out(ft));
   lsdm_monitor u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
      .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
      .pslverr_out(err), .sample_valid_in(vld), .model_pos_in(mp),
      .fback_pos_in(fp), .model_spd_in(ms), .fback_spd_in(fs),
      .cmd_thr_in(ct), .fback_thr_in(ft),
      .position_deviation_alarm_out(pal),
      .speed_deviation_alarm_out(sal),
      .thrust_deviation_alarm_out(tal), .motor_stop_out(stp),
      .irq_out(irq));
   // ----
   // Shared tasks
   // ----
   task automatic close_out;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; request held until pready is seen high,
   // only the hang guard ends a wait that never finishes
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (rdy !== 1'b1);
      q = prd;
      err_q = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // One valid sample; returns once its alarm edge has landed
   task automatic smp(input lsdm_val_t p, s, t);
      dp <= p;
      ds <= s;
      dt <= t;
      fire <= 1'b1;
      @(posedge clk_in);
      fire <= 1'b0;
      @(posedge clk_in);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_reset;
      rdc(`LSDM_OFF_SELECT, 32'h3);
      rdc(`LSDM_OFF_POS_LIM, 32'h32);
      rdc(`LSDM_OFF_SPD_LIM, 32'h3e8);
      rdc(`LSDM_OFF_THR_LIM, 32'h64);
      rdc(8'h28, 32'h0);
      chk({31'h0, err_q}, 32'h1);
   endtask
   task automatic t_pos;
      smp(24'sd49, 24'sd0, 24'sd0);
      chk(al, 32'h0);
      smp(-24'sd50, 24'sd0, 24'sd0);
      chk(al, 32'h1);
      @(posedge clk_in);
      chk({31'h0, stp}, 32'h1);
      repeat (5) @(posedge clk_in);
      chk({30'h0, irq, pal}, 32'h1);
      apb(1'b1, `LSDM_OFF_MASK, 32'h1);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `LSDM_OFF_STATUS, 32'h1);
      chk({30'h0, irq, pal}, 32'h0);
      @(posedge clk_in);
      chk({31'h0, stp}, 32'h0);
   endtask
   task automatic t_spd;
      smp(24'sd0, 24'sd1000, 24'sd0);
      chk(al, 32'h0);
      smp(24'sd0, -24'sd1001, 24'sd0);
      chk(al, 32'h2);
      apb(1'b1, `LSDM_OFF_STATUS, 32'h7);
   endtask
   // Every selection value against a sample that breaks all limits
   task automatic t_sel;
      for (int s = 0; s < 8; s++) begin
         apb(1'b1, `LSDM_OFF_SELECT, 32'(s));
         smp(24'sd2000, 24'sd2000, 24'sd2000);
         chk(al, 32'(s));
         apb(1'b1, `LSDM_OFF_STATUS, 32'h7);
      end
   endtask
   // Out-of-range limits clamp; then boundaries at new limits
   task automatic t_lim;
      apb(1'b1, `LSDM_OFF_POS_LIM, 32'h0);
      rdc(`LSDM_OFF_POS_LIM, 32'h1);
      apb(1'b1, `LSDM_OFF_POS_LIM, 32'h7d0);
      rdc(`LSDM_OFF_POS_LIM, 32'h3e8);
      apb(1'b1, `LSDM_OFF_SPD_LIM, 32'h1770);
      rdc(`LSDM_OFF_SPD_LIM, 32'h1388);
      apb(1'b1, `LSDM_OFF_THR_LIM, 32'h7d0);
      rdc(`LSDM_OFF_THR_LIM, 32'h3e8);
      apb(1'b1, `LSDM_OFF_THR_LIM, 32'h64);
      smp(24'sd999, 24'sd0, 24'sd100);
      chk(al, 32'h0);
      smp(24'sd1000, 24'sd0, -24'sd101);
      chk(al, 32'h5);
      // Live outcome and peaks: largest deviation came from t_sel
      rdc(`LSDM_OFF_LIVE, 32'hd);
      rdc(`LSDM_OFF_PEAK_POS, 32'h7d0);
      rdc(`LSDM_OFF_PEAK_SPD, 32'h7d0);
      rdc(`LSDM_OFF_PEAK_THR, 32'h7d0);
      apb(1'b1, `LSDM_OFF_PEAK_POS, 32'h0);
      rdc(`LSDM_OFF_PEAK_POS, 32'h0);
   endtask
   // ----
   // Main sequence and hang guard
   // ----
   initial begin
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      t_reset;
      t_pos;
      t_spd;
      t_sel;
      t_lim;
      close_out;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         close_out;
      end
   end
endmodule
`default_nettype wire
